// File: mtc_pkg.sv
// package: register map, field layout and codes of the modem clock synthesiser
package mtc_pkg;
   // ------------------------------------------------------------------
   // register map (byte addresses)
   // ------------------------------------------------------------------
   localparam int          NCH         = 9;
   localparam int          SIDE_BIT    = 5;
   localparam logic [7:0]  STATUS_OFF  = 8'h40;
   localparam logic [7:0]  PAT_BASE    = 8'h80;
   localparam logic [1:0]  KIND_NONE   = 2'h0;
   localparam logic [1:0]  KIND_SIDE   = 2'h1;
   localparam logic [1:0]  KIND_STAT   = 2'h2;
   localparam logic [1:0]  KIND_PAT    = 2'h3;
   localparam logic [1:0]  IDX_CTRL    = 2'h0;
   localparam logic [1:0]  IDX_FREQ    = 2'h1;
   localparam logic [1:0]  IDX_CORR    = 2'h2;
   localparam logic [1:0]  IDX_PHASE   = 2'h3;
   // ------------------------------------------------------------------
   // fields and reset values
   // ------------------------------------------------------------------
   localparam int          RXEN_BIT    = 2;
   localparam int          PER_LSB     = 16;
   localparam logic [2:0]  CTRL_RST_TX = 3'h0;
   localparam logic [2:0]  CTRL_RST_RX = 3'h4;
   localparam logic [31:0] FREQ_RST    = 32'h2000_0000;
   localparam logic [31:0] CORR_RST    = 32'h0;
   localparam logic [31:0] PAT_RST     = 32'h0;
   localparam logic [7:0]  OHC_WRAP    = 8'hfe;
   localparam logic [1:0]  RESP_OK     = 2'h0;
   localparam logic [1:0]  RESP_SLVERR = 2'h2;
   // ------------------------------------------------------------------
   // reference codes, pin slots and channel slots
   // ------------------------------------------------------------------
   localparam logic [1:0]  TXREF_INT   = 2'h0;
   localparam logic [1:0]  TXREF_LOOP  = 2'h1;
   localparam logic [1:0]  TXREF_TERR  = 2'h2;
   localparam logic [1:0]  RXREF_SYM   = 2'h0;
   localparam logic [1:0]  RXREF_TERR  = 2'h1;
   localparam logic [1:0]  RXREF_STN   = 2'h2;
   localparam int          PIN_INT     = 0;
   localparam int          PIN_SYM     = 1;
   localparam int          PIN_TERR    = 2;
   localparam int          PIN_STN     = 3;
   localparam int          CH_TX_INFO  = 0;
   localparam int          CH_TX_FRAME = 1;
   localparam int          CH_TX_CONV  = 2;
   localparam int          CH_TX_BLOCK = 3;
   localparam int          CH_RX_INFO  = 4;
   localparam int          CH_RX_FRAME = 5;
   localparam int          CH_RX_CONV  = 6;
   localparam int          CH_RX_BLOCK = 7;
   localparam int          CH_RX_DEMOD = 8;
endpackage

// File: mtc_clock_synth.sv
// top: transmit and receive timing generators behind an axi4-lite slave
//
// The placing of the registers and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/1ns
// What this block does
// - this unit sources every board clock except processor and baud-rate clocks
// - transmit side gives info, framing, overhead channel, convolutional, block clocks
// - transmit overhead channel clock runs at exactly info rate times 256/255 when info keep is at most 255/256 of period
// - transmit clocks come from a sequencer deleting oscillator pulses
// - external transmit reference enables the loop; processor writes corrections
// - transmit reference is internal oscillator, receive symbol clock or external
// - receive side gives overhead, symbol, info, framing and demodulator clocks
// - receive oscillator rate is processor set; clocks punctured from it
// - receive side locks to recovered symbol clock; processor writes corrections
// - receive reference is recovered symbol clock or external clock
module mtc_clock_synth
   import mtc_pkg::*;
(
   input  wire logic        aclk,           // 125 mhz clock
   input  wire logic        aresetn,        // synchronous reset, low
   input  wire logic [7:0]  s_axi_awaddr,   // write address
   input  wire logic        s_axi_awvalid,  // write address valid
   output logic             s_axi_awready,  // write address ready
   input  wire logic [31:0] s_axi_wdata,    // write data
   input  wire logic [3:0]  s_axi_wstrb,    // byte enables
   input  wire logic        s_axi_wvalid,   // write data valid
   output logic             s_axi_wready,   // write data ready
   output logic [1:0]       s_axi_bresp,    // write response
   output logic             s_axi_bvalid,   // write response valid
   input  wire logic        s_axi_bready,   // write response ready
   input  wire logic [7:0]  s_axi_araddr,   // read address
   input  wire logic        s_axi_arvalid,  // read address valid
   output logic             s_axi_arready,  // read address ready
   output logic [31:0]      s_axi_rdata,    // read data
   output logic [1:0]       s_axi_rresp,    // read response
   output logic             s_axi_rvalid,   // read data valid
   input  wire logic        s_axi_rready,   // read data ready
   input  wire logic        int_ref_clk,    // internal reference oscillator
   input  wire logic        rx_sym_clk,     // recovered symbol clock
   input  wire logic        terr_clk,       // terrestrial data clock
   input  wire logic        station_clk,    // station clock
   output logic             tx_info_clk,    // transmit information pulse
   output logic             tx_frame_clk,   // transmit framing overhead pulse
   output logic             tx_ohc_clk,     // transmit overhead channel pulse
   output logic             tx_conv_clk,    // transmit convolutional symbol pulse
   output logic             tx_block_clk,   // transmit block-code symbol pulse
   output logic             rx_info_clk,    // receive information pulse
   output logic             rx_frame_clk,   // receive framing overhead pulse
   output logic             rx_ohc_clk,     // receive overhead channel pulse
   output logic             rx_conv_clk,    // receive convolutional symbol pulse
   output logic             rx_block_clk,   // receive block-code symbol pulse
   output logic             rx_demod_clk    // demodulator clock pulse
);
   // ------------------------------------------------------------------
   // declarations
   // ------------------------------------------------------------------
   logic [2:0]      ctrl_q [2];
   logic [31:0]     freq_q [2];
   logic [31:0]     corr_q [2];
   logic [31:0]     pat_q  [NCH];
   logic [1:0]      tick_w, new_w, pll_st_w, pll_w, ref_edge_w, clr_w, ohc_w;
   logic [31:0]     phase_w [2];
   logic [NCH-1:0]  hit_w, pulse_w;
   logic [3:0]      pin_w, s1_q, s2_q, s3_q, lvl_q, prv_q, edge_w;
   logic            awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
   logic [1:0]      bresp_q, rresp_q;
   logic [7:0]      awaddr_q;
   logic [31:0]     wdata_q, rdata_q, rd_w;
   logic [3:0]      wstrb_q;
   logic [5:0]      wsel_w, rsel_w;
   logic            aw_hs_w, w_hs_w, b_hs_w, ar_hs_w, r_hs_w, wr_fire_w;

   function automatic logic [5:0] reg_sel(input logic [7:0] a);
      logic [5:0] r;
      r = {KIND_NONE, 4'h0};
      if (a[1:0] == 2'b00) begin
         if (a[7:6] == 2'b00 && a[4] == 1'b0)
            r = {KIND_SIDE, 1'b0, a[SIDE_BIT], a[3:2]};
         else if (a == STATUS_OFF)
            r = {KIND_STAT, 4'h0};
         else if (a[7:6] == PAT_BASE[7:6] && a[5:2] < 4'(NCH))
            r = {KIND_PAT, a[5:2]};
      end
      return r;
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d,
                                         input logic [3:0] s);
      logic [31:0] r;
      r = o;
      for (int b = 0; b < 4; b++) begin
         if (s[b])
            r[8*b +: 8] = d[8*b +: 8];
      end
      return r;
   endfunction

   // ------------------------------------------------------------------
   // axi4-lite slave
   // ------------------------------------------------------------------
   assign aw_hs_w   = s_axi_awvalid & awready_q;
   assign w_hs_w    = s_axi_wvalid & wready_q;
   assign b_hs_w    = bvalid_q & s_axi_bready;
   assign ar_hs_w   = s_axi_arvalid & arready_q;
   assign r_hs_w    = rvalid_q & s_axi_rready;
   assign wr_fire_w = ~awready_q & ~wready_q & ~bvalid_q;
   assign wsel_w    = reg_sel(awaddr_q);
   assign rsel_w    = reg_sel(s_axi_araddr);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready_q <= 1'b1;
         wready_q  <= 1'b1;
         bvalid_q  <= 1'b0;
         bresp_q   <= RESP_OK;
         awaddr_q  <= 8'h0;
         wdata_q   <= 32'h0;
         wstrb_q   <= 4'h0;
      end else begin
         if (aw_hs_w) begin
            awready_q <= 1'b0;
            awaddr_q  <= s_axi_awaddr;
         end else if (b_hs_w) begin
            awready_q <= 1'b1;
         end
         if (w_hs_w) begin
            wready_q <= 1'b0;
            wdata_q  <= s_axi_wdata;
            wstrb_q  <= s_axi_wstrb;
         end else if (b_hs_w) begin
            wready_q <= 1'b1;
         end
         if (wr_fire_w) begin
            bvalid_q <= 1'b1;
            bresp_q  <= (wsel_w[5:4] == KIND_NONE) ? RESP_SLVERR : RESP_OK;
         end else if (b_hs_w) begin
            bvalid_q <= 1'b0;
         end
      end
   end

   always_comb begin
      rd_w = 32'h0;
      case (rsel_w[5:4])
         KIND_SIDE: begin
            case (rsel_w[1:0])
               IDX_CTRL: rd_w = {29'h0, ctrl_q[rsel_w[2]]};
               IDX_FREQ: rd_w = freq_q[rsel_w[2]];
               IDX_CORR: rd_w = corr_q[rsel_w[2]];
               default:  rd_w = phase_w[rsel_w[2]];
            endcase
         end
         KIND_STAT: rd_w = {28'h0, pll_st_w, new_w};
         KIND_PAT:  rd_w = pat_q[rsel_w[3:0]];
         default:   rd_w = 32'h0;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_q <= 1'b1;
         rvalid_q  <= 1'b0;
         rdata_q   <= 32'h0;
         rresp_q   <= RESP_OK;
      end else if (ar_hs_w) begin
         arready_q <= 1'b0;
         rvalid_q  <= 1'b1;
         rdata_q   <= rd_w;
         rresp_q   <= (rsel_w[5:4] == KIND_NONE) ? RESP_SLVERR : RESP_OK;
      end else if (r_hs_w) begin
         arready_q <= 1'b1;
         rvalid_q  <= 1'b0;
      end
   end

   // ------------------------------------------------------------------
   // control registers
   // ------------------------------------------------------------------
   // phase-capture status bits 0 and 1 are write-one-to-clear, loop bits are read-only; a capture in the same cycle wins
   for (genvar j = 0; j < 2; j++) begin : g_clr
      assign clr_w[j] = wr_fire_w & (wsel_w[5:4] == KIND_STAT) & wstrb_q[0] & wdata_q[j];
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_q[0] <= CTRL_RST_TX;
         ctrl_q[1] <= CTRL_RST_RX;
         for (int j = 0; j < 2; j++) begin
            freq_q[j] <= FREQ_RST;
            corr_q[j] <= CORR_RST;
         end
         for (int c = 0; c < NCH; c++)
            pat_q[c] <= PAT_RST;
      end else if (wr_fire_w && wsel_w[5:4] == KIND_SIDE) begin
         case (wsel_w[1:0])
            IDX_CTRL: ctrl_q[wsel_w[2]] <= wstrb_q[0] ? wdata_q[2:0] : ctrl_q[wsel_w[2]];
            IDX_FREQ: freq_q[wsel_w[2]] <= merge(freq_q[wsel_w[2]], wdata_q, wstrb_q);
            IDX_CORR: corr_q[wsel_w[2]] <= merge(corr_q[wsel_w[2]], wdata_q, wstrb_q);
            default:  ;
         endcase
      end else if (wr_fire_w && wsel_w[5:4] == KIND_PAT) begin
         pat_q[wsel_w[3:0]] <= merge(pat_q[wsel_w[3:0]], wdata_q, wstrb_q);
      end
   end

   // ------------------------------------------------------------------
   // reference pins and selection
   // ------------------------------------------------------------------
   // a level counts once the second and third stages agree
   assign pin_w  = {station_clk, terr_clk, rx_sym_clk, int_ref_clk};
   assign edge_w = lvl_q & ~prv_q;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s1_q  <= 4'h0;
         s2_q  <= 4'h0;
         s3_q  <= 4'h0;
         lvl_q <= 4'h0;
         prv_q <= 4'h0;
      end else begin
         s1_q  <= pin_w;
         s2_q  <= s1_q;
         s3_q  <= s2_q;
         lvl_q <= (s2_q & s3_q) | (lvl_q & (s2_q | s3_q));
         prv_q <= lvl_q;
      end
   end

   assign ref_edge_w[0] = (ctrl_q[0][1:0] == TXREF_INT)  ? edge_w[PIN_INT] :
                          (ctrl_q[0][1:0] == TXREF_LOOP) ? pulse_w[CH_RX_CONV] :
                          (ctrl_q[0][1:0] == TXREF_TERR) ? edge_w[PIN_TERR] : edge_w[PIN_STN];
   assign ref_edge_w[1] = (ctrl_q[1][1:0] == RXREF_SYM)  ? edge_w[PIN_SYM] :
                          (ctrl_q[1][1:0] == RXREF_TERR) ? edge_w[PIN_TERR] :
                          (ctrl_q[1][1:0] == RXREF_STN)  ? edge_w[PIN_STN] : 1'b0;
   // loop on for any external tx reference
   assign pll_w[0] = (ctrl_q[0][1:0] != TXREF_INT);
   assign pll_w[1] = ctrl_q[1][RXEN_BIT];

   // ------------------------------------------------------------------
   // oscillators and phase capture, one per side
   // ------------------------------------------------------------------
   for (genvar j = 0; j < 2; j++) begin : g_side
      logic [31:0] acc_q, phase_q, step_w;
      logic [32:0] sum_w;
      logic        tick_q, new_q, guard_q, pll_q, chg_w, take_w;
      logic [1:0]  sel_prv_q;
      // correction added while the loop runs
      assign step_w = pll_q ? 32'(freq_q[j] + corr_q[j]) : freq_q[j];
      // oscillator tick is the accumulator carry
      assign sum_w  = {1'b0, acc_q} + {1'b0, step_w};
      assign chg_w  = (sel_prv_q != ctrl_q[j][1:0]);
      // first edge after a source change may be partial: dropped
      assign take_w = ref_edge_w[j] & pll_q & ~guard_q & ~chg_w;
      always_ff @(posedge aclk) begin
         if (!aresetn) begin
            acc_q     <= 32'h0;
            tick_q    <= 1'b0;
            pll_q     <= 1'b0;
            sel_prv_q <= 2'h0;
            guard_q   <= 1'b0;
            phase_q   <= 32'h0;
            new_q     <= 1'b0;
         end else begin
            acc_q     <= sum_w[31:0];
            tick_q    <= sum_w[32];
            pll_q     <= pll_w[j];
            sel_prv_q <= ctrl_q[j][1:0];
            if (chg_w)
               guard_q <= 1'b1;
            else if (ref_edge_w[j])
               guard_q <= 1'b0;
            if (take_w)
               phase_q <= acc_q;
            if (take_w)
               new_q <= 1'b1;
            else if (clr_w[j])
               new_q <= 1'b0;
         end
      end
      assign tick_w[j]   = tick_q;
      assign phase_w[j]  = phase_q;
      assign new_w[j]    = new_q;
      assign pll_st_w[j] = pll_q;
   end

   // ------------------------------------------------------------------
   // puncturing sequencers
   // ------------------------------------------------------------------
   // keep must not exceed period; period zero silences the channel
   for (genvar c = 0; c < NCH; c++) begin : g_ch
      logic [15:0] frac_q, per_w;
      logic [16:0] sum_w;
      logic        tk_w, p_q;
      assign tk_w  = (c < CH_RX_INFO) ? tick_w[0] : tick_w[1];
      assign per_w = pat_q[c][PER_LSB +: 16];
      assign sum_w = {1'b0, frac_q} + {1'b0, pat_q[c][15:0]};
      // pass a tick only when the fraction wraps
      assign hit_w[c] = tk_w & (per_w != 16'h0) & (sum_w >= {1'b0, per_w});
      always_ff @(posedge aclk) begin
         if (!aresetn) begin
            frac_q <= 16'h0;
            p_q    <= 1'b0;
         end else begin
            if (tk_w)
               frac_q <= hit_w[c] ? 16'(sum_w - {1'b0, per_w}) : sum_w[15:0];
            p_q <= hit_w[c];
         end
      end
      assign pulse_w[c] = p_q;
   end

   // one extra pulse after every 255 info pulses
   for (genvar j = 0; j < 2; j++) begin : g_ohc
      logic [7:0] cnt_q;
      logic       pend_q, ohc_q, inf_w, srv_w, wrap_w;
      assign inf_w  = hit_w[j ? CH_RX_INFO : CH_TX_INFO];
      assign wrap_w = inf_w & (cnt_q == OHC_WRAP);
      assign srv_w  = tick_w[j] & pend_q & ~inf_w;
      always_ff @(posedge aclk) begin
         if (!aresetn) begin
            cnt_q  <= 8'h0;
            pend_q <= 1'b0;
            ohc_q  <= 1'b0;
         end else begin
            cnt_q <= wrap_w ? 8'h0 : 8'(cnt_q + {7'h0, inf_w});
            if (wrap_w)
               pend_q <= 1'b1;
            else if (srv_w)
               pend_q <= 1'b0;
            ohc_q <= inf_w | srv_w;
         end
      end
      assign ohc_w[j] = ohc_q;
   end

   // ------------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------------
   // every clock leaves straight from a flop
   assign tx_info_clk   = pulse_w[CH_TX_INFO];
   assign tx_frame_clk  = pulse_w[CH_TX_FRAME];
   assign tx_ohc_clk    = ohc_w[0];
   assign tx_conv_clk   = pulse_w[CH_TX_CONV];
   assign tx_block_clk  = pulse_w[CH_TX_BLOCK];
   assign rx_info_clk   = pulse_w[CH_RX_INFO];
   assign rx_frame_clk  = pulse_w[CH_RX_FRAME];
   assign rx_ohc_clk    = ohc_w[1];
   assign rx_conv_clk   = pulse_w[CH_RX_CONV];
   assign rx_block_clk  = pulse_w[CH_RX_BLOCK];
   assign rx_demod_clk  = pulse_w[CH_RX_DEMOD];
   assign s_axi_awready = awready_q;
   assign s_axi_wready  = wready_q;
   assign s_axi_bresp   = bresp_q;
   assign s_axi_bvalid  = bvalid_q;
   assign s_axi_arready = arready_q;
   assign s_axi_rdata   = rdata_q;
   assign s_axi_rresp   = rresp_q;
   assign s_axi_rvalid  = rvalid_q;

   // ------------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------------
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence s_tx_chg;
      $changed(ctrl_q[0][1:0]);
   endsequence
   sequence s_rx_take;
      g_side[1].take_w;
   endsequence

   property p_tx_ohc;
      pulse_w[CH_TX_INFO] |-> ohc_w[0];
   endproperty
   a_tx_ohc: assert property (p_tx_ohc) else $error("tx info pulse without ohc");
   property p_ohc_extra;
      ohc_w[0] && !pulse_w[CH_TX_INFO] |-> $past(g_ohc[0].pend_q) && !g_ohc[0].pend_q;
   endproperty
   a_ohc_extra: assert property (p_ohc_extra) else $error("stray ohc pulse");
   property p_rx_ohc;
      pulse_w[CH_RX_INFO] |-> ohc_w[1];
   endproperty
   a_rx_ohc: assert property (p_rx_ohc) else $error("rx info pulse without ohc");
   property p_tx_punct;
      pulse_w[CH_TX_CONV] |-> $past(tick_w[0]);
   endproperty
   a_tx_punct: assert property (p_tx_punct) else $error("tx pulse off tick");
   property p_rx_punct;
      pulse_w[CH_RX_DEMOD] |-> $past(tick_w[1]);
   endproperty
   a_rx_punct: assert property (p_rx_punct) else $error("rx pulse off tick");
   property p_tx_pll;
      pll_st_w[0] == ($past(ctrl_q[0][1:0]) != TXREF_INT);
   endproperty
   a_tx_pll: assert property (p_tx_pll) else $error("tx loop enable wrong");
   property p_tx_free;
      !pll_st_w[0] |-> g_side[0].step_w == freq_q[0];
   endproperty
   a_tx_free: assert property (p_tx_free) else $error("correction used off loop");
   property p_rx_lock;
      s_rx_take |=> new_w[1] && phase_w[1] == $past(g_side[1].acc_q);
   endproperty
   a_rx_lock: assert property (p_rx_lock) else $error("rx phase not captured");
   property p_rx_sel;
      ctrl_q[1][1:0] == RXREF_TERR |-> ref_edge_w[1] == edge_w[PIN_TERR];
   endproperty
   a_rx_sel: assert property (p_rx_sel) else $error("rx reference mux wrong");
   property p_tx_guard;
      s_tx_chg |-> !g_side[0].take_w ##1 !g_side[0].take_w;
   endproperty
   a_tx_guard: assert property (p_tx_guard) else $error("edge taken at switch");
endmodule

// File: mtc_ref_model.sv
// partner: free-running reference oscillators seen by the clock synthesiser
`timescale 1ns/1ns
module mtc_ref_model (
   output logic int_ref_clk,  // internal reference oscillator
   output logic rx_sym_clk,   // recovered symbol clock
   output logic terr_clk,     // terrestrial data clock
   output logic station_clk   // station clock
);
   // ------------------------------------------------------------------
   // reference sources
   // ------------------------------------------------------------------
   // sources run free of aclk; an edge landing on aclk is absorbed by the synchroniser
   initial begin
      int_ref_clk = 1'b0;
      rx_sym_clk  = 1'b0;
      terr_clk    = 1'b0;
      station_clk = 1'b0;
   end
   always #50 int_ref_clk = ~int_ref_clk;
   always #37 rx_sym_clk = ~rx_sym_clk;
   always #61 terr_clk = ~terr_clk;
   always #83 station_clk = ~station_clk;
endmodule

// File: modem_tx_rx_clock_synth_tb.sv
// testbench: register access, pulse rates, overhead ratio and reference loop status
`timescale 1ns/1ns
`define CHK(n, e, s) begin total_checks++; if ((e) !== (s)) begin fails++; \
   $display("BAD %s exp %0h got %0h", n, e, s); end end
module modem_tx_rx_clock_synth_tb;
   import mtc_pkg::*;
   logic        aclk = 1'b0, aresetn = 1'b0;
   logic [7:0]  awaddr = 8'h0, araddr = 8'h0;
   logic [31:0] wdata = 32'h0, rd;
   logic [3:0]  wstrb = 4'h0;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [1:0]  rs;
   logic [10:0] pq = 11'h0;
   wire         awready, wready, bvalid, arready, rvalid, tx_ohc, rx_ohc;
   wire  [1:0]  bresp, rresp;
   wire  [31:0] rdata;
   wire         int_ref_clk, rx_sym_clk, terr_clk, station_clk;
   wire  [8:0]  pulse;
   wire  [10:0] pv = {rx_ohc, tx_ohc, pulse};
   int          fails = 0, total_checks = 0, pc [0:10] = '{default: 0};
   int          i, s, per, kp, c0, c1, c2, c3, ti, to;
   always #4 aclk = ~aclk;
   mtc_ref_model refs (.int_ref_clk(int_ref_clk), .rx_sym_clk(rx_sym_clk),
      .terr_clk(terr_clk), .station_clk(station_clk));
   mtc_clock_synth uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .int_ref_clk(int_ref_clk), .rx_sym_clk(rx_sym_clk),
      .terr_clk(terr_clk), .station_clk(station_clk), .tx_info_clk(pulse[CH_TX_INFO]),
      .tx_frame_clk(pulse[CH_TX_FRAME]), .tx_ohc_clk(tx_ohc), .tx_conv_clk(pulse[CH_TX_CONV]),
      .tx_block_clk(pulse[CH_TX_BLOCK]), .rx_info_clk(pulse[CH_RX_INFO]),
      .rx_frame_clk(pulse[CH_RX_FRAME]), .rx_ohc_clk(rx_ohc), .rx_conv_clk(pulse[CH_RX_CONV]),
      .rx_block_clk(pulse[CH_RX_BLOCK]), .rx_demod_clk(pulse[CH_RX_DEMOD]));
   // ------------------------------------------------------------------
   // pulse counters and width monitor
   // ------------------------------------------------------------------
   always @(posedge aclk) begin
      if (aresetn) begin
         for (int k = 0; k < 11; k++) pc[k] += pv[k];
         `CHK("pulse width", 11'h0, pv & pq)
      end
      pq <= pv;
   end
   // ------------------------------------------------------------------
   // bus tasks: bready and rready stay high, so every answer is taken at once
   // ------------------------------------------------------------------
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      awaddr <= a;
      wdata <= d;
      wstrb <= 4'hf;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      // only the watchdog ends a wait for the answer
      do begin
         @(posedge aclk);
         if (awready === 1'b1) awvalid <= 1'b0;
         if (wready === 1'b1) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      rs = bresp;
   endtask
   task automatic rdr(input logic [7:0] a);
      araddr <= a;
      arvalid <= 1'b1;
      do begin
         @(posedge aclk);
         if (arready === 1'b1) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      rd = rdata;
      rs = rresp;
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
      rdr(a);
      `CHK("rdata", e, rd)
      `CHK("rresp", er, rs)
   endtask
   function automatic int exp_pulses(int ticks, int keep, int period);
      return ticks * keep / period;
   endfunction
   task finish_test;
      $display("checks %0d fails %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   initial begin
      #320000;
      fails++;
      finish_test;
   end
   // ------------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------------
   initial begin
      void'($urandom(32'h3855f697));
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      bready <= 1'b1;
      rready <= 1'b1;
      @(posedge aclk);
      for (s = 0; s < 2; s++) begin
         rchk(8'(s * 32), s ? {29'h0, CTRL_RST_RX} : {29'h0, CTRL_RST_TX}, RESP_OK);
         rchk(8'(s * 32 + 4), FREQ_RST, RESP_OK);
         rchk(8'(s * 32 + 8), CORR_RST, RESP_OK);
      end
      for (i = 0; i < NCH; i++) rchk(PAT_BASE + 8'(4 * i), PAT_RST, RESP_OK);
      rchk(8'h10, 32'h0, RESP_SLVERR);
      wr(8'h14, 32'hffff_ffff);
      `CHK("bresp", RESP_SLVERR, rs)
      // one tick every four cycles on both sides
      wr(8'h04, 32'h4000_0000);
      wr(8'h24, 32'h4000_0000);
      for (i = 0; i < NCH; i++) begin
         per = 1 + $urandom % 15;
         kp = (i == CH_RX_DEMOD) ? per : 1 + $urandom % per;
         wr(PAT_BASE + 8'(4 * i), {per[15:0], kp[15:0]});
         repeat (20) @(posedge aclk);
         c0 = pc[i];
         repeat (2000) @(posedge aclk);
         c1 = pc[i] - c0;
         c2 = exp_pulses(500, kp, per);
         `CHK("pulses", 1'b1, (c1 >= c2 - 2 && c1 <= c2 + 2))
         wr(PAT_BASE + 8'(4 * i), 32'h0);
      end
      wr(8'h04, 32'h8000_0000);
      wr(8'h24, 32'h8000_0000);
      wr(PAT_BASE + 8'(4 * CH_TX_INFO), 32'h0002_0001);
      wr(PAT_BASE + 8'(4 * CH_RX_INFO), 32'h0002_0001);
      for (s = 0; s < 2; s++) begin
         repeat (20) @(posedge aclk);
         c0 = pc[4 * s];
         c3 = pc[9 + s];
         repeat (4000) @(posedge aclk);
         ti = pc[4 * s] - c0;
         to = pc[9 + s] - c3 - ti;
         `CHK("info", 1'b1, (ti >= 998 && ti <= 1002))
         `CHK("ohc extra", 1'b1, (to >= ti / 255 - 1 && to <= ti / 255 + 1))
      end
      // rx conv pulses on every rx tick feed the loop-timing reference
      wr(PAT_BASE + 8'(4 * CH_RX_CONV), 32'h0001_0001);
      for (i = 0; i < 4; i++) begin
         wr(8'h00, 32'(i));
         wr(8'h20, 32'(4 + i));
         wr(STATUS_OFF, 32'h3);
         repeat (300) @(posedge aclk);
         rdr(STATUS_OFF);
         `CHK("tx loop", (i != 0), rd[2])
         `CHK("tx phase", (i != 0), rd[0])
         `CHK("rx loop", 1'b1, rd[3])
         `CHK("rx phase", (i != 3), rd[1])
      end
      // step stays below half scale so rx ticks never land back to back
      wr(8'h28, 32'hf234_5678);
      rchk(8'h28, 32'hf234_5678, RESP_OK);
      wr(8'h20, 32'h0);
      rdr(STATUS_OFF);
      `CHK("rx loop off", 1'b0, rd[3])
      finish_test;
   end
endmodule
